/* hdl/fault_flag_pkg.sv */
// constants for the fault status flag bank: register offsets, field
// positions, reset values and widths.
// assumes a byte-wide register port driven by the control-bus front end.
package fault_flag_pkg;

    // register width and address width
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    // live (present-condition) registers
    localparam logic [7:0] OFS_LIVE_CLOCK_SUPPLY    = 8'h44;
    localparam logic [7:0] OFS_LIVE_THERMAL_REG     = 8'h47;
    localparam logic [7:0] OFS_LIVE_BROWNOUT        = 8'h48;
    // latched (sticky) registers
    localparam logic [7:0] OFS_LATCHED_PROTECTION   = 8'h49;
    localparam logic [7:0] OFS_LATCHED_CHECKSUM     = 8'h4a;
    localparam logic [7:0] OFS_LATCHED_CLOCK_SUPPLY = 8'h4b;
    // mask registers, one per latched register
    localparam logic [7:0] OFS_MASK_PROTECTION      = 8'h3b;
    localparam logic [7:0] OFS_MASK_CHECKSUM        = 8'h3c;
    localparam logic [7:0] OFS_MASK_CLOCK_SUPPLY    = 8'h3d;
    // clock/interrupt configuration register holding the clear command
    localparam logic [7:0] OFS_CLEAR_CONTROL        = 8'h5c;

    // field positions
    localparam int unsigned POS_CLOCK_ERROR     = 7;
    localparam int unsigned POS_BATTERY_UV      = 5;
    localparam int unsigned POS_TEMP_LSB        = 4;
    localparam int unsigned POS_REGULATOR_LSB   = 1;
    localparam int unsigned POS_LOCKOUT         = 0;
    localparam int unsigned POS_THERMAL_LSB     = 6;
    localparam int unsigned POS_SUPPLY_DIFF     = 5;
    localparam int unsigned POS_BROWNOUT_ACTIVE = 4;
    localparam int unsigned POS_BROWNOUT_LVL    = 0;
    localparam int unsigned POS_OTP_CHECKSUM    = 6;
    localparam int unsigned POS_LOAD_DONE       = 5;
    localparam int unsigned POS_LOAD_RESULT_LSB = 3;
    localparam int unsigned POS_CLEAR_COMMAND   = 2;

    // status registers all reset to zero
    localparam logic [7:0] RST_STATUS           = 8'h00;
    // mask reset values
    localparam logic [7:0] RST_MASK_PROTECTION  = 8'hfc;
    localparam logic [7:0] RST_MASK_CHECKSUM    = 8'hbe;
    localparam logic [7:0] RST_MASK_CLOCK_SUPPLY = 8'hdf;

    // load-diagnostic result codes
    localparam logic [1:0] LOAD_NORMAL = 2'h0;
    localparam logic [1:0] LOAD_OPEN   = 2'h1;
    localparam logic [1:0] LOAD_SHORT  = 2'h2;

    // width of the synchronised condition vector
    localparam int unsigned COND_W = 30;

endpackage

/* hdl/sticky_flag_bank.sv */
// a bank of sticky flags that a condition sets and a clear pulse resets.
// assumes set and clear are both on the core clock and already synchronised.
`timescale 1ns/1ns
`default_nettype none
module sticky_flag_bank
    import fault_flag_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // condition and clear
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic             clear_i,
    // held flags
    output logic      [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // a condition present in the clear cycle is kept, so no event is lost
    always_comb begin
        if (clear_i) begin
            flags_next = set_i;
        end else begin
            flags_next = flags_reg | set_i;
        end
    end

    // flags reset to zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;

endmodule
`default_nettype wire

/* hdl/fault_status_flag_bank.sv */
// fault status flag bank: live and latched fault flags, masks, clear
// command and the interrupt request of an audio amplifier.
// assumes the control-bus front end drives the byte register port on the
// core clock; fault conditions arrive from analog/other domains.
//
// Functional notes
// - clock error live flag, 0x44 bit 7
// - battery undervoltage live flag, 0x44 bit 5
// - four die-temperature flags, 0x47 bits 7-4
// - regulator uv/ov/overload live, 0x47 bits 3-1
// - power-stage lockout live flag, 0x47 bit 0
// - thermal threshold two and one, bits 7-6
// - supply difference low flag, bit 5
// - brownout active bit 4, levels bits 3-0
// - latch brownout mute and hold, 0x49 bits 7-6
// - latch limiter events, 0x49 bits 5-3
// - latch audio port clock error, bit 2
// - latch over-current bit 1, over-temperature bit 0
// - latch checksum error, 0x4a bit 6
// - latch load diagnostics done, 0x4a bit 5
// - load result code in 0x4a bits 4-3
// - latched clock error and battery undervoltage, 0x4b
// - status read-only, reset zero, reserved zero
// - mask bit one suppresses source interrupt
// - self-clearing bit clears all latched registers, except flags whose condition is still present
`timescale 1ns/1ns
`default_nettype none
module fault_status_flag_bank
    import fault_flag_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    // register port from the control-bus front end
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_rd_i,
    input  wire logic              reg_wr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // clock and supply conditions
    input  wire logic              live_internal_clock_error_i,
    input  wire logic              live_battery_rail_undervoltage_i,
    input  wire logic [3:0]        live_temp_over_i,
    input  wire logic [2:0]        live_regulator_fault_i,
    input  wire logic              live_power_stage_lockout_i,
    // thermal detect and brownout conditions
    input  wire logic [1:0]        live_thermal_detect_i,
    input  wire logic              live_supply_difference_low_i,
    input  wire logic              live_brownout_active_i,
    input  wire logic [3:0]        live_brownout_level_i,
    // protection events
    input  wire logic              brownout_mute_i,
    input  wire logic              brownout_infinite_hold_i,
    input  wire logic              limiter_max_atten_i,
    input  wire logic              below_inflection_i,
    input  wire logic              limiter_active_i,
    input  wire logic              audio_port_clock_error_i,
    input  wire logic              over_current_i,
    input  wire logic              over_temperature_i,
    // checksum and load diagnostics
    input  wire logic              otp_checksum_error_i,
    input  wire logic              load_diag_done_i,
    input  wire logic [1:0]        load_fault_result_i,
    // results
    output logic                   irq_o,
    output logic                   shutdown_o
);

    // reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // condition synchroniser: conditions come from outside the clock domain
    logic [COND_W-1:0] cond_raw;
    logic [COND_W-1:0] cond_meta_reg;
    logic [COND_W-1:0] cond_reg;
    logic [COND_W-1:0] cond_meta_next;
    logic [COND_W-1:0] cond_next;

    assign cond_raw = {live_internal_clock_error_i, live_battery_rail_undervoltage_i,
                       live_temp_over_i, live_regulator_fault_i,
                       live_power_stage_lockout_i, live_thermal_detect_i,
                       live_supply_difference_low_i, live_brownout_active_i,
                       live_brownout_level_i,
                       brownout_mute_i, brownout_infinite_hold_i, limiter_max_atten_i,
                       below_inflection_i, limiter_active_i, audio_port_clock_error_i,
                       over_current_i, over_temperature_i,
                       otp_checksum_error_i, load_diag_done_i, load_fault_result_i};

    always_comb begin
        cond_meta_next = cond_raw;
        cond_next      = cond_meta_reg;
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cond_meta_reg <= '0;
            cond_reg      <= '0;
        end else begin
            cond_meta_reg <= cond_meta_next;
            cond_reg      <= cond_next;
        end
    end

    // unpack synchronised conditions
    logic       s_clock_error;
    logic       s_battery_uv;
    logic [3:0] s_temp_over;
    logic [2:0] s_regulator;
    logic       s_lockout;
    logic [1:0] s_thermal;
    logic       s_supply_diff;
    logic       s_bo_active;
    logic [3:0] s_bo_level;
    logic [7:0] s_protection;
    logic       s_otp;
    logic       s_load_done;
    logic [1:0] s_load_result;

    assign {s_clock_error, s_battery_uv, s_temp_over, s_regulator, s_lockout,
            s_thermal, s_supply_diff, s_bo_active, s_bo_level,
            s_protection, s_otp, s_load_done, s_load_result} = cond_reg;

    // live register images, reserved bits tied to zero
    logic [7:0] live_clock_supply_faults;
    logic [7:0] live_thermal_regulator_faults;
    logic [7:0] live_brownout_threshold_flags;

    always_comb begin
        live_clock_supply_faults      = RST_STATUS;
        live_thermal_regulator_faults = RST_STATUS;
        live_brownout_threshold_flags = RST_STATUS;
        live_clock_supply_faults[POS_CLOCK_ERROR] = s_clock_error;
        live_clock_supply_faults[POS_BATTERY_UV]  = s_battery_uv;
        live_thermal_regulator_faults[POS_TEMP_LSB +: 4]      = s_temp_over;
        live_thermal_regulator_faults[POS_REGULATOR_LSB +: 3] = s_regulator;
        live_thermal_regulator_faults[POS_LOCKOUT]            = s_lockout;
        live_brownout_threshold_flags[POS_THERMAL_LSB +: 2]   = s_thermal;
        live_brownout_threshold_flags[POS_SUPPLY_DIFF]        = s_supply_diff;
        live_brownout_threshold_flags[POS_BROWNOUT_ACTIVE]    = s_bo_active;
        live_brownout_threshold_flags[POS_BROWNOUT_LVL +: 4]  = s_bo_level;
    end

    // clear command: a write of one yields a single-cycle pulse
    logic clear_pulse_reg;
    logic clear_pulse_next;

    always_comb begin
        clear_pulse_next = reg_wr_i && (reg_addr_i == OFS_CLEAR_CONTROL)
                           && reg_wdata_i[POS_CLEAR_COMMAND];
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            clear_pulse_reg <= 1'b0;
        end else begin
            clear_pulse_reg <= clear_pulse_next;
        end
    end

    // sticky set vectors for the latched registers
    logic [7:0] set_protection;
    logic [7:0] set_checksum;
    logic [7:0] set_clock_supply;

    always_comb begin
        set_checksum     = RST_STATUS;
        set_clock_supply = RST_STATUS;
        set_protection = s_protection;
        set_checksum[POS_OTP_CHECKSUM] = s_otp;
        set_checksum[POS_LOAD_DONE]    = s_load_done;
        // latched clock error and battery uv
        set_clock_supply[POS_CLOCK_ERROR] = s_clock_error;
        set_clock_supply[POS_BATTERY_UV]  = s_battery_uv;
    end

    logic [7:0] latched_protection_events;
    logic [7:0] latched_checksum_flags;
    logic [7:0] latched_clock_supply_faults;

    sticky_flag_bank #(.WIDTH(8)) protection_bank (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_sync_reg),
        .set_i   (set_protection),
        .clear_i (clear_pulse_reg),
        .flags_o (latched_protection_events)
    );

    sticky_flag_bank #(.WIDTH(8)) checksum_bank (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_sync_reg),
        .set_i   (set_checksum),
        .clear_i (clear_pulse_reg),
        .flags_o (latched_checksum_flags)
    );

    sticky_flag_bank #(.WIDTH(8)) clock_supply_bank (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_sync_reg),
        .set_i   (set_clock_supply),
        .clear_i (clear_pulse_reg),
        .flags_o (latched_clock_supply_faults)
    );

    // load result is captured on the rising edge of the done condition,
    // since the code itself is a value, not a flag to be or-ed
    logic       load_done_prev_reg;
    logic       load_done_prev_next;
    logic [1:0] load_result_reg;
    logic [1:0] load_result_next;

    always_comb begin
        load_done_prev_next = s_load_done;
        load_result_next    = load_result_reg;
        if (clear_pulse_reg) begin
            load_result_next = LOAD_NORMAL;
        end
        if (s_load_done && !load_done_prev_reg) begin
            load_result_next = s_load_result;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            load_done_prev_reg <= 1'b0;
            load_result_reg    <= LOAD_NORMAL;
        end else begin
            load_done_prev_reg <= load_done_prev_next;
            load_result_reg    <= load_result_next;
        end
    end

    logic [7:0] latched_checksum_load_diag;

    always_comb begin
        latched_checksum_load_diag = latched_checksum_flags;
        latched_checksum_load_diag[POS_LOAD_RESULT_LSB +: 2] = load_result_reg;
    end

    // mask registers: software writes every bit, reads back what it wrote
    logic [7:0] mask_protection_reg;
    logic [7:0] mask_checksum_reg;
    logic [7:0] mask_clock_supply_reg;
    logic [7:0] mask_protection_next;
    logic [7:0] mask_checksum_next;
    logic [7:0] mask_clock_supply_next;

    always_comb begin
        mask_protection_next   = mask_protection_reg;
        mask_checksum_next     = mask_checksum_reg;
        mask_clock_supply_next = mask_clock_supply_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_MASK_PROTECTION: begin
                    mask_protection_next = reg_wdata_i;
                end
                OFS_MASK_CHECKSUM: begin
                    mask_checksum_next = reg_wdata_i;
                end
                OFS_MASK_CLOCK_SUPPLY: begin
                    mask_clock_supply_next = reg_wdata_i;
                end
                default: begin
                    mask_protection_next = mask_protection_reg;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            mask_protection_reg   <= RST_MASK_PROTECTION;
            mask_checksum_reg     <= RST_MASK_CHECKSUM;
            mask_clock_supply_reg <= RST_MASK_CLOCK_SUPPLY;
        end else begin
            mask_protection_reg   <= mask_protection_next;
            mask_checksum_reg     <= mask_checksum_next;
            mask_clock_supply_reg <= mask_clock_supply_next;
        end
    end

    // read decode; unmapped addresses and writes to status registers are
    // ignored and read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input logic [7:0] live_a,
                                            input logic [7:0] live_b,
                                            input logic [7:0] live_c,
                                            input logic [7:0] ltch_a,
                                            input logic [7:0] ltch_b,
                                            input logic [7:0] ltch_c,
                                            input logic [7:0] msk_a,
                                            input logic [7:0] msk_b,
                                            input logic [7:0] msk_c);
        logic [7:0] value;
        value = RST_STATUS;
        case (addr)
            OFS_LIVE_CLOCK_SUPPLY:    value = live_a;
            OFS_LIVE_THERMAL_REG:     value = live_b;
            OFS_LIVE_BROWNOUT:        value = live_c;
            OFS_LATCHED_PROTECTION:   value = ltch_a;
            OFS_LATCHED_CHECKSUM:     value = ltch_b;
            OFS_LATCHED_CLOCK_SUPPLY: value = ltch_c;
            OFS_MASK_PROTECTION:      value = msk_a;
            OFS_MASK_CHECKSUM:        value = msk_b;
            OFS_MASK_CLOCK_SUPPLY:    value = msk_c;
            default:                  value = RST_STATUS;
        endcase
        return value;
    endfunction

    // read data, interrupt and shutdown registers
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       irq_reg;
    logic       irq_next;
    logic       shutdown_reg;
    logic       shutdown_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            rdata_next = read_mux(reg_addr_i,
                                  live_clock_supply_faults,
                                  live_thermal_regulator_faults,
                                  live_brownout_threshold_flags,
                                  latched_protection_events,
                                  latched_checksum_load_diag,
                                  latched_clock_supply_faults,
                                  mask_protection_reg,
                                  mask_checksum_reg,
                                  mask_clock_supply_reg);
        end
        irq_next = |(latched_protection_events & ~mask_protection_reg)
                 | |(latched_checksum_load_diag & ~mask_checksum_reg)
                 | |(latched_clock_supply_faults & ~mask_clock_supply_reg);
        shutdown_next = s_clock_error | s_battery_uv | (|s_regulator) | s_lockout;
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg    <= RST_STATUS;
            irq_reg      <= 1'b0;
            shutdown_reg <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            irq_reg      <= irq_next;
            shutdown_reg <= shutdown_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign irq_o       = irq_reg;
    assign shutdown_o  = shutdown_reg;

endmodule
`default_nettype wire

/* verification/fault_status_flag_bank_assertions.sv */
// port checker for the fault status flag bank.
// assumes the bench never masks the over-current source.
`timescale 1ns/1ns
`default_nettype none
module fault_status_flag_bank_checker
    import fault_flag_pkg::*;
(
    // clock, reset and register port
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_rd_i,
    input  wire logic              reg_wr_i,
    input  wire logic [DATA_W-1:0] reg_rdata_o,
    // shutdown causes, one event and results
    input  wire logic              live_internal_clock_error_i,
    input  wire logic              live_battery_rail_undervoltage_i,
    input  wire logic [2:0]        live_regulator_fault_i,
    input  wire logic              live_power_stage_lockout_i,
    input  wire logic              over_current_i,
    input  wire logic              irq_o,
    input  wire logic              shutdown_o
);
    logic [3:0] since_wr_reg;
    logic [3:0] since_wr_next;
    logic       cause;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // cycles since the last write; an irq may only drop shortly after one
    always_comb begin
        since_wr_next = (since_wr_reg == 4'hf) ? since_wr_reg : since_wr_reg + 4'h1;
        if (reg_wr_i) begin
            since_wr_next = 4'h0;
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            since_wr_reg <= 4'hf;
        end else begin
            since_wr_reg <= since_wr_next;
        end
    end
    // any condition that forces shutdown
    assign cause = live_internal_clock_error_i | live_battery_rail_undervoltage_i
                 | (|live_regulator_fault_i) | live_power_stage_lockout_i;

    AST_SD_CLOCK_ERROR: assert property (
        live_internal_clock_error_i [*8] |-> shutdown_o) else $error("no shutdown on clock error");
    AST_SD_BATTERY_UV: assert property (
        live_battery_rail_undervoltage_i [*8] |-> shutdown_o) else $error("no shutdown on rail uv");
    AST_SD_REGULATOR: assert property (
        (|live_regulator_fault_i) [*8] |-> shutdown_o) else $error("no shutdown on regulator");
    AST_SD_LOCKOUT: assert property (
        live_power_stage_lockout_i [*8] |-> shutdown_o) else $error("no shutdown on lockout");
    AST_SD_QUIET: assert property (
        !cause [*8] |-> !shutdown_o) else $error("shutdown without cause");
    AST_IRQ_OVER_CURRENT: assert property (
        over_current_i [*8] |-> irq_o) else $error("no irq on over-current");
    AST_IRQ_FALL: assert property (
        $fell(irq_o) |-> since_wr_reg <= 4'h6) else $error("irq dropped without a write");
    AST_RDATA_HOLD: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
    AST_RSV_CLOCK_SUPPLY: assert property (
        reg_rd_i && (reg_addr_i == OFS_LIVE_CLOCK_SUPPLY || reg_addr_i == OFS_LATCHED_CLOCK_SUPPLY)
        |=> (reg_rdata_o & 8'h5f) == 8'h00) else $error("reserved clock-supply bits set");
    AST_RSV_LOAD: assert property (
        reg_rd_i && reg_addr_i == OFS_LATCHED_CHECKSUM
        |=> (reg_rdata_o & 8'h87) == 8'h00) else $error("reserved load bits set");

    // main scenarios
    COV_CLEAR: cover property (reg_wr_i && reg_addr_i == OFS_CLEAR_CONTROL);
    COV_IRQ: cover property ($rose(irq_o));
    COV_SD: cover property ($rose(shutdown_o));
endmodule

bind fault_status_flag_bank fault_status_flag_bank_checker i_checker (
    .core_clk_i, .reset_n_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_rdata_o,
    .live_internal_clock_error_i, .live_battery_rail_undervoltage_i,
    .live_regulator_fault_i, .live_power_stage_lockout_i, .over_current_i,
    .irq_o, .shutdown_o
);
`default_nettype wire

/* verification/test_fault_status_flag_bank.sv */
// self-checking bench for the fault status flag bank.
// assumes read data shows one cycle after the read strobe is taken.
`timescale 1ns/1ns
`default_nettype none
module test_fault_status_flag_bank
    import fault_flag_pkg::*;
;
    logic       core_clk;
    logic       reset_n;
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       clk_err;
    logic       bat_uv;
    logic [7:0] v47;
    logic [7:0] v48;
    logic [7:0] v49;
    logic       otp;
    logic       done;
    logic [1:0] res;
    logic       irq;
    logic       sd;
    int         n_mismatch;
    int         total_checks;
    int         cycles;
    // every status register offset
    logic [7:0] stat_ofs [6] = '{OFS_LIVE_CLOCK_SUPPLY, OFS_LIVE_THERMAL_REG,
        OFS_LIVE_BROWNOUT, OFS_LATCHED_PROTECTION, OFS_LATCHED_CHECKSUM,
        OFS_LATCHED_CLOCK_SUPPLY};

    fault_status_flag_bank i_dut (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .live_internal_clock_error_i(clk_err), .live_battery_rail_undervoltage_i(bat_uv),
        .live_temp_over_i(v47[7:4]), .live_regulator_fault_i(v47[3:1]),
        .live_power_stage_lockout_i(v47[0]), .live_thermal_detect_i(v48[7:6]),
        .live_supply_difference_low_i(v48[5]), .live_brownout_active_i(v48[4]),
        .live_brownout_level_i(v48[3:0]), .brownout_mute_i(v49[7]),
        .brownout_infinite_hold_i(v49[6]), .limiter_max_atten_i(v49[5]),
        .below_inflection_i(v49[4]), .limiter_active_i(v49[3]),
        .audio_port_clock_error_i(v49[2]), .over_current_i(v49[1]),
        .over_temperature_i(v49[0]), .otp_checksum_error_i(otp),
        .load_diag_done_i(done), .load_fault_result_i(res), .irq_o(irq), .shutdown_o(sd)
    );

    // free-running clock
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            finish_test();
        end
    end

    // wait n edges, then step just past the last one
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        total_checks++;
        if (rdata !== exp) begin
            n_mismatch++;
            $display("ERROR %0t read %h got %h want %h", $time, a, rdata, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        step(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    // clear pulse, then let the latches settle
    task automatic clear();
        wr_reg(OFS_CLEAR_CONTROL, 8'h04);
        step(4);
    endtask

    initial begin
        {addr, rd, wr, wdata, clk_err, bat_uv, v47, v48, v49, otp, done, res} = '0;
        reset_n = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(posedge core_clk);
        #1 reset_n = 1'b1;
        step(3);
        // reset values, write attempts on status, unmapped places
        wr_reg(OFS_LATCHED_PROTECTION, 8'hff);
        wr_reg(OFS_LIVE_CLOCK_SUPPLY, 8'hff);
        foreach (stat_ofs[i]) rd_chk(stat_ofs[i], 8'h00);
        rd_chk(8'h00, 8'h00);
        rd_chk(OFS_CLEAR_CONTROL, 8'h00);
        rd_chk(OFS_MASK_PROTECTION, RST_MASK_PROTECTION);
        rd_chk(OFS_MASK_CHECKSUM, RST_MASK_CHECKSUM);
        rd_chk(OFS_MASK_CLOCK_SUPPLY, RST_MASK_CLOCK_SUPPLY);
        // clock error and rail undervoltage, live and latched
        clk_err = 1'b1;
        bat_uv = 1'b1;
        step(6);
        rd_chk(OFS_LIVE_CLOCK_SUPPLY, 8'ha0);
        rd_chk(OFS_LATCHED_CLOCK_SUPPLY, 8'ha0);
        chk_bit(sd, 1'b1);
        chk_bit(irq, 1'b1);
        clk_err = 1'b0;
        step(6);
        rd_chk(OFS_LIVE_CLOCK_SUPPLY, 8'h20);
        rd_chk(OFS_LATCHED_CLOCK_SUPPLY, 8'ha0);
        clear();
        rd_chk(OFS_LATCHED_CLOCK_SUPPLY, 8'h20);
        chk_bit(sd, 1'b1);
        // clock error alone must still shut down
        {clk_err, bat_uv} = 2'b10;
        step(6);
        chk_bit(sd, 1'b1);
        clk_err = 1'b0;
        clear();
        rd_chk(OFS_LATCHED_CLOCK_SUPPLY, 8'h00);
        chk_bit(irq, 1'b0);
        chk_bit(sd, 1'b0);
        // walk one bit downwards; over-current and over-temperature are the only unmasked protection events
        for (int b = 7; b >= 0; b--) begin
            v47 = 8'(1 << b);
            v48 = 8'(1 << b);
            v49 = 8'(1 << b);
            step(6);
            rd_chk(OFS_LIVE_THERMAL_REG, 8'(1 << b));
            rd_chk(OFS_LIVE_BROWNOUT, 8'(1 << b));
            rd_chk(OFS_LATCHED_PROTECTION, 8'(8'hff << b));
            chk_bit(sd, b < 4);
            {v47, v48, v49} = '0;
        end
        step(6);
        rd_chk(OFS_LIVE_BROWNOUT, 8'h00);
        rd_chk(OFS_LATCHED_PROTECTION, 8'hff);
        chk_bit(irq, 1'b1);
        clear();
        rd_chk(OFS_LATCHED_PROTECTION, 8'h00);
        chk_bit(irq, 1'b0);
        // masked event stays quiet until its mask bit is cleared
        v49 = 8'h80;
        step(6);
        chk_bit(irq, 1'b0);
        wr_reg(OFS_MASK_PROTECTION, 8'h7c);
        step(2);
        chk_bit(irq, 1'b1);
        wr_reg(OFS_MASK_PROTECTION, RST_MASK_PROTECTION);
        v49 = 8'h00;
        clear();
        chk_bit(irq, 1'b0);
        // checksum error, then every load result code
        otp = 1'b1;
        step(6);
        otp = 1'b0;
        rd_chk(OFS_LATCHED_CHECKSUM, 8'h40);
        chk_bit(irq, 1'b1);
        clear();
        for (int c = 0; c < 3; c++) begin
            res = 2'(c);
            done = 1'b1;
            step(6);
            rd_chk(OFS_LATCHED_CHECKSUM, 8'h20 | 8'(c << 3));
            chk_bit(irq, 1'b0);
            clear();
            rd_chk(OFS_LATCHED_CHECKSUM, 8'h20);
            done = 1'b0;
            step(6);
            clear();
            rd_chk(OFS_LATCHED_CHECKSUM, 8'h00);
        end
        finish_test();
    end
endmodule
`default_nettype wire
